/* spi_flash_guard_pkg.sv */
package spi_flash_guard_pkg;
   localparam int unsigned CLK_MHZ         = 50;
   localparam int unsigned PROG_TIME_US    = 1500;
   localparam int unsigned SECT_ERASE_MS   = 500;
   localparam int unsigned BULK_ERASE_MS   = 6000;
   localparam int unsigned STAT_WRITE_MS   = 15;
   localparam int unsigned PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
   localparam int unsigned SECT_CYCLES     = SECT_ERASE_MS * 1000 * CLK_MHZ;
   localparam int unsigned BULK_CYCLES     = BULK_ERASE_MS * 1000 * CLK_MHZ;
   localparam int unsigned STAT_CYCLES     = STAT_WRITE_MS * 1000 * CLK_MHZ;

   localparam logic [7:0] LATCH_SET_CMD    = 8'h06;
   localparam logic [7:0] LATCH_CLEAR_CMD  = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] PAGE_WRITE_CMD   = 8'h02;
   localparam logic [7:0] SECTOR_WIPE_CMD  = 8'hD8;
   localparam logic [7:0] FULL_WIPE_CMD    = 8'hC7;

   // Status byte layout
   localparam int unsigned CYCLE_ACTIVE_POS = 0;
   localparam int unsigned WRITE_LATCH_POS  = 1;
   localparam int unsigned BLOCK_GUARD_LSB  = 2;
   localparam int unsigned STATUS_LOCK_POS  = 7;
   localparam logic [2:0]  BLOCK_GUARD_RST  = 3'h0;
   localparam logic        STATUS_LOCK_RST  = 1'b0;

   // Frame bit counts
   localparam logic [5:0] CMD_BITS   = 6'h08;
   localparam logic [5:0] STAT_BITS  = 6'h10;
   localparam logic [5:0] ADDR_BITS  = 6'h20;
   localparam logic [5:0] PROG_BITS  = 6'h28;
   localparam logic [5:0] BITS_MAX   = 6'h3F;

   localparam int unsigned SECTOR_LSB = 16;
   localparam int unsigned SECTOR_MSB = 19;

   typedef enum logic [1:0] {
      OP_PROGRAM = 2'b00,
      OP_SECTOR  = 2'b01,
      OP_BULK    = 2'b10
   } array_op_t;

   typedef struct packed {
      logic        valid;
      array_op_t   op;
      logic [23:0] addr;
   } array_cmd_t;

   // Protected range per guard code
   function automatic logic guard_hit(input logic [2:0] bp, input logic [23:0] addr);
      case (bp)
         3'h0:    guard_hit = 1'b0;
         3'h1:    guard_hit = (addr[SECTOR_MSB:SECTOR_LSB] == 4'hF);
         3'h2:    guard_hit = (addr[SECTOR_MSB:SECTOR_LSB+1] == 3'h7);
         3'h3:    guard_hit = (addr[SECTOR_MSB:SECTOR_LSB+2] == 2'h3);
         3'h4:    guard_hit = addr[SECTOR_MSB];
         default: guard_hit = 1'b1;
      endcase
   endfunction : guard_hit
endpackage : spi_flash_guard_pkg

/* spi_flash_protect_hold_status.sv */
`timescale 1ns/10ps
// What this block does
// R1: Busy flag high exactly while a status-write, program or erase cycle runs.
// R2: Controller may poll the busy flag instead of waiting worst case.
// R3: Write-latch flag mirrors the internal write latch.
// R4: Three guard bits are kept and select the shielded array portion.
// R5: Guard codes map to none, top 1/16, 1/8, 1/4, 1/2, or everything.
// R6: Lock bit plus asserted write-guard pin freezes lock and guard bits.
// R7: Controller sets the latch before every program, erase or status write.
// R8: Latch clears on power-up, latch-clear, and end of write cycles.
// R9: Write-type instructions run only if clock count is a multiple of eight.
// R10: Active while selected or busy, otherwise standby.
// R11: Pause gates the serial clock and never aborts a running cycle.
// R12: Controller asserts pause only while chip select is low.
// R13: Pause starts at pause fall if clock low, else at next clock low.
// R14: Pause ends at pause rise if clock low, else at next clock low.
// R15: While paused, output floats and clock and data input are ignored.
// R16: Deselect during pause resets the interface, dropping the instruction.
// R17: Controller releases pause before selecting again after such deselect.
// R18: Sixteen 64 KiB sectors; sector n starts at n times 10000h.
// R19: Program only clears bits; erase sets them back to one.
// R20: Status register readable at any time, even during a cycle.
// R21: Status bits: busy 0, latch 1, guard 4:2, lock 7.
// R22: Program or erase aimed at a protected address is ignored.
module spi_flash_protect_hold_status
   import spi_flash_guard_pkg::*;
#(
   parameter int unsigned PROG_CNT = PROG_CYCLES,
   parameter int unsigned SECT_CNT = SECT_CYCLES,
   parameter int unsigned BULK_CNT = BULK_CYCLES,
   parameter int unsigned STAT_CNT = STAT_CYCLES
) (
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        sck_i,
   input  wire logic        cs_n_i,
   input  wire logic        si_i,
   input  wire logic        hold_n_i,
   input  wire logic        wp_n_i,
   output logic             so_o,
   output logic             so_oe_n_o,
   output logic [7:0]       status_flags_o,
   output logic             power_active_o,
   output array_cmd_t       array_cmd_o
);
   logic [4:0]  sync1;
   logic [4:0]  sync2;
   logic        sck_d;
   logic        cs_d;
   logic        sck_s, cs_s, si_s, hold_s, wp_s;

   logic        paused,      next_paused;
   logic [5:0]  nbits,       next_nbits;
   logic [2:0]  phase,       next_phase;
   logic [31:0] shreg,       next_shreg;
   logic [7:0]  cmd,         next_cmd;
   logic [23:0] addr,        next_addr;
   logic [7:0]  wdata,       next_wdata;
   logic        reading,     next_reading;
   logic [2:0]  out_idx,     next_out_idx;
   logic        so,          next_so;
   logic        latch,       next_latch;
   logic [2:0]  bp,          next_bp;
   logic        lock,        next_lock;
   logic [31:0] timer,       next_timer;
   array_cmd_t  acmd,        next_acmd;

   logic sck_rise, sck_fall, cs_rise, busy, hard_guard, clk_ok;

   // Pins are asynchronous to the system clock
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         // Idle pin levels, so that no false clock edge follows reset
         sync1 <= 5'h0B;
         sync2 <= 5'h0B;
         sck_d <= 1'b0;
         cs_d  <= 1'b1;
      end else begin
         sync1 <= {sck_i, cs_n_i, si_i, hold_n_i, wp_n_i};
         sync2 <= sync1;
         sck_d <= sck_s;
         cs_d  <= cs_s;
      end
   end

   assign {sck_s, cs_s, si_s, hold_s, wp_s} = sync2;
   assign busy       = (timer != 32'h0); // R1
   assign hard_guard = lock & ~wp_s; // R6
   assign clk_ok     = ~cs_s & ~paused; // R11 R15
   assign sck_rise   = clk_ok & sck_s & ~sck_d;
   assign sck_fall   = clk_ok & ~sck_s & sck_d;
   assign cs_rise    = cs_s & ~cs_d;

   always_comb begin
      next_paused  = paused;
      next_nbits   = nbits;
      next_phase   = phase;
      next_shreg   = shreg;
      next_cmd     = cmd;
      next_addr    = addr;
      next_wdata   = wdata;
      next_reading = reading;
      next_out_idx = out_idx;
      next_so      = so;
      next_latch   = latch;
      next_bp      = bp;
      next_lock    = lock;
      next_timer   = busy ? timer - 32'h1 : timer; // R11
      next_acmd    = '0;

      if (timer == 32'h1) begin
         next_latch = 1'b0; // R8
      end

      // Pause tracks the synchronised clock level: entry or exit waits for it low
      if (cs_s) begin
         next_paused = 1'b0;
      end else if (!sck_s) begin
         next_paused = ~hold_s; // R13 R14
      end

      if (sck_rise) begin
         next_shreg = {shreg[30:0], si_s};
         next_phase = phase + 3'h1;
         if (nbits != BITS_MAX) begin
            next_nbits = nbits + 6'h1;
         end
         if (nbits == CMD_BITS - 6'h1) begin
            next_cmd     = {shreg[6:0], si_s};
            next_reading = ({shreg[6:0], si_s} == STATUS_READ_CMD); // R20
         end
         if (nbits == STAT_BITS - 6'h1) begin
            next_wdata = {shreg[6:0], si_s};
         end
         if (nbits == ADDR_BITS - 6'h1) begin
            next_addr = {shreg[22:0], si_s};
         end
      end

      if (sck_fall && reading) begin
         next_so      = status_flags_o[3'h7 - out_idx];
         next_out_idx = out_idx + 3'h1;
      end

      if (cs_rise) begin
         next_nbits   = 6'h0;
         next_phase   = 3'h0;
         next_reading = 1'b0;
         next_out_idx = 3'h0;
         next_cmd     = 8'h00;
         // Deselect while paused drops the frame unexecuted
         if (!paused && !busy && phase == 3'h0 && nbits != 6'h0) begin // R16 R9
            if (cmd == LATCH_SET_CMD && nbits == CMD_BITS) begin
               next_latch = 1'b1; // R3
            end else if (cmd == LATCH_CLEAR_CMD && nbits == CMD_BITS) begin
               next_latch = 1'b0; // R8
            end else if (cmd == STATUS_WRITE_CMD && latch && nbits == STAT_BITS
                         && !hard_guard) begin // R6
               next_bp    = wdata[BLOCK_GUARD_LSB +: 3]; // R4
               next_lock  = wdata[STATUS_LOCK_POS];
               next_timer = STAT_CNT;
            end else if (cmd == PAGE_WRITE_CMD && latch && nbits >= PROG_BITS
                         && !guard_hit(bp, addr)) begin // R22 R5
               next_acmd  = '{valid: 1'b1, op: OP_PROGRAM, addr: addr}; // R19
               next_timer = PROG_CNT;
            end else if (cmd == SECTOR_WIPE_CMD && latch && nbits == ADDR_BITS
                         && !guard_hit(bp, addr)) begin // R22
               next_acmd  = '{valid: 1'b1, op: OP_SECTOR, addr: addr}; // R18 R19
               next_timer = SECT_CNT;
            end else if (cmd == FULL_WIPE_CMD && latch && nbits == CMD_BITS
                         && bp == 3'h0) begin // R22
               next_acmd  = '{valid: 1'b1, op: OP_BULK, addr: 24'h0}; // R19
               next_timer = BULK_CNT;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         paused  <= 1'b0;
         nbits   <= 6'h0;
         phase   <= 3'h0;
         shreg   <= 32'h0;
         cmd     <= 8'h00;
         addr    <= 24'h0;
         wdata   <= 8'h00;
         reading <= 1'b0;
         out_idx <= 3'h0;
         so      <= 1'b0;
         latch   <= 1'b0; // R8
         bp      <= BLOCK_GUARD_RST;
         lock    <= STATUS_LOCK_RST;
         timer   <= 32'h0;
         acmd    <= '0;
      end else begin
         paused  <= next_paused;
         nbits   <= next_nbits;
         phase   <= next_phase;
         shreg   <= next_shreg;
         cmd     <= next_cmd;
         addr    <= next_addr;
         wdata   <= next_wdata;
         reading <= next_reading;
         out_idx <= next_out_idx;
         so      <= next_so;
         latch   <= next_latch;
         bp      <= next_bp;
         lock    <= next_lock;
         timer   <= next_timer;
         acmd    <= next_acmd;
      end
   end

   assign status_flags_o = {lock, 2'b00, bp, latch, busy}; // R21
   assign so_o           = so;
   assign so_oe_n_o      = ~(reading & clk_ok); // R15
   assign power_active_o = ~cs_s | busy; // R10
   assign array_cmd_o    = acmd;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_cycle_end;
      busy ##1 !busy;
   endsequence

   sequence s_deselect;
      cs_s & ~cs_d;
   endsequence

   a_busy_start:   assert property ($rose(busy) |-> $past(cs_rise) && $past(phase) == 3'h0) // R1
      else $error("busy rose without an aligned deselect");
   a_frame_count:  assert property (s_deselect ##0 (phase != 3'h0) // R9
                                    |=> !acmd.valid && !$rose(busy))
      else $error("misaligned frame started a cycle");
   a_latch_clear:  assert property (s_cycle_end |-> !status_flags_o[WRITE_LATCH_POS]) // R8
      else $error("latch still set after cycle end");
   a_latch_set:    assert property ($rose(latch) |-> $past(cmd) == LATCH_SET_CMD) // R3
      else $error("latch set by wrong command");
   a_hard_guard:   assert property (hard_guard |=> $stable(bp) && $stable(lock)) // R6
      else $error("guard bits changed in hard guard mode");
   a_guard_range:  assert property (acmd.valid && acmd.op != OP_BULK // R22
                                    |-> !guard_hit(bp, acmd.addr))
      else $error("operation issued into protected range");
   a_pause_enter:  assert property (!cs_s && !hold_s && !sck_s |=> paused) // R13
      else $error("pause not entered with clock low");
   a_pause_exit:   assert property (paused && !cs_s && hold_s && !sck_s |=> !paused) // R14
      else $error("pause not left with clock low");
   a_pause_float:  assert property (paused && !cs_s |-> so_oe_n_o // R15
                                    ##1 ($stable(nbits) && $stable(so)))
      else $error("output driven or clock used while paused");
   a_standby:      assert property (busy |-> power_active_o) // R10
      else $error("standby entered during a cycle");
endmodule : spi_flash_protect_hold_status

/* spi_host_model.sv */
`timescale 1ns/10ps
module spi_host_model (
   input  wire logic sys_clk_i,
   input  wire logic so_i,
   input  wire logic so_oe_n_i,
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      si_o,
   output logic      hold_n_o
);
   logic paused_oe;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      hold_n_o = 1'b1;
      paused_oe = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : tick
   // Half a link clock period is four system cycles
   task automatic frame(input logic [39:0] tx, input int nbits, input int hold_at,
                        input bit drop, output logic [39:0] rx);
      int i;
      rx = '0;
      cs_n_o <= 1'b0;
      tick(4);
      for (i = 0; i < nbits; i++) begin
         if (i == hold_at) begin
            hold_n_o <= 1'b0;
            tick(4);
            sck_o <= 1'b1;
            tick(4);
            paused_oe = so_oe_n_i;
            sck_o <= 1'b0;
            tick(4);
            if (drop) begin
               cs_n_o <= 1'b1;
               tick(4);
               hold_n_o <= 1'b1;
               tick(8);
               return;
            end
            hold_n_o <= 1'b1;
            tick(4);
         end
         si_o <= tx[nbits-1-i];
         tick(4);
         sck_o <= 1'b1;
         tick(4);
         // Sampled late in the high phase, well after the output settled
         rx = {rx[38:0], so_i};
         sck_o <= 1'b0;
      end
      tick(4);
      cs_n_o <= 1'b1;
      si_o <= ~si_o;
      tick(8);
   endtask : frame
endmodule : spi_host_model

/* testbench.sv */
`timescale 1ns/10ps
module testbench
   import spi_flash_guard_pkg::*;
;
   logic        sys_clk, nrst, wp_n, sck, cs_n, si, hold_n, so, so_oe_n, power_active;
   logic [7:0]  status_flags;
   array_cmd_t  array_cmd, last_cmd;
   logic [39:0] rx;
   logic [23:0] a;
   logic [23:0] bases [8] = '{24'h100000, 24'hF0000, 24'hE0000, 24'hC0000,
                              24'h80000, 24'h0, 24'h0, 24'h0};
   int          n_fail, n_checks, n_pulse, p, b, k;
   spi_flash_protect_hold_status #(.PROG_CNT(30), .SECT_CNT(40), .BULK_CNT(60),
      .STAT_CNT(200)) uut (.sys_clk_i(sys_clk), .nrst_i(nrst), .sck_i(sck),
      .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so),
      .so_oe_n_o(so_oe_n), .status_flags_o(status_flags),
      .power_active_o(power_active), .array_cmd_o(array_cmd));
   spi_host_model host (.sys_clk_i(sys_clk), .so_i(so), .so_oe_n_i(so_oe_n),
      .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (array_cmd.valid === 1'b1) begin
         n_pulse <= n_pulse + 1;
         last_cmd <= array_cmd;
      end
   end
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic cmd(input logic [39:0] tx, input int n);
      host.frame(tx, n, -1, 1'b0, rx);
   endtask : cmd
   task automatic wait_idle();
      int i;
      for (i = 0; i < 400 && status_flags[0] !== 1'b0; i++) @(posedge sys_clk);
      check(status_flags[0], 1'b0);
   endtask : wait_idle
   task automatic wr_status(input logic [7:0] v);
      cmd(40'h06, 8);
      cmd({8'h01, v}, 16);
      wait_idle();
   endtask : wr_status
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   initial begin
      #1ms;
      n_fail++;
      final_report();
   end
   initial begin
      nrst = 1'b0;
      wp_n = 1'b1;
      n_fail = 0;
      n_checks = 0;
      n_pulse = 0;
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      host.tick(4);
      check(status_flags, 8'h00);
      check({power_active, so_oe_n}, 2'b01);
      cmd(40'h06, 8);
      check(status_flags, 8'h02);
      cmd(40'h04, 8);
      check(status_flags, 8'h00);
      $display("test reset and latch done");
      cmd(40'h06, 8);
      cmd(40'h0184, 16);
      check({status_flags[0], power_active}, 2'b11);
      host.frame(40'h0500, 16, -1, 1'b0, rx);
      check(rx[7:0], 8'h87);
      wait_idle();
      check({status_flags, power_active}, {8'h84, 1'b0});
      wp_n <= 1'b0;
      cmd(40'h06, 8);
      cmd(40'h0100, 16);
      check(status_flags, 8'h86);
      wp_n <= 1'b1;
      cmd(40'h0100, 16);
      wait_idle();
      check(status_flags, 8'h00);
      $display("test status write done");
      for (b = 0; b < 8; b++) begin
         wr_status(8'(b << 2));
         check(status_flags, 8'(b << 2));
         for (k = 0; k < 2; k++) begin
            a = bases[b] - 24'(1 - k);
            p = n_pulse;
            cmd(40'h06, 8);
            cmd({8'hD8, a}, 32);
            check(n_pulse - p, ((k == 0) ? (b < 5) : (b == 0)));
            if (n_pulse != p) check(last_cmd, {1'b1, OP_SECTOR, a});
            wait_idle();
         end
      end
      wr_status(8'h00);
      $display("test guard map done");
      cmd(40'h06, 8);
      p = n_pulse;
      cmd(40'h6C091A2B, 31);
      check({n_pulse - p, status_flags}, {32'h0, 8'h02});
      cmd({8'h02, 24'h051234, 8'hA5}, 40);
      check(last_cmd, {1'b1, OP_PROGRAM, 24'h051234});
      wait_idle();
      check(status_flags, 8'h00);
      cmd(40'h06, 8);
      cmd(40'hC7, 8);
      check({n_pulse - p, last_cmd.op}, {32'h2, OP_BULK});
      wait_idle();
      $display("test array ops done");
      // Pause inside a running status write must not cut the cycle short
      cmd(40'h06, 8);
      cmd(40'h0100, 16);
      host.frame(40'h0500, 16, 14, 1'b0, rx);
      check({rx[7:0], host.paused_oe}, {8'h03, 1'b1});
      wait_idle();
      check(status_flags, 8'h00);
      // A whole latch-set byte is in when the pause deselect drops it
      host.frame(40'h0600, 16, 8, 1'b1, rx);
      check(status_flags, 8'h00);
      cmd(40'h06, 8);
      check(status_flags, 8'h02);
      $display("test hold done");
      final_report();
   end
endmodule : testbench
